// ===== core/scr_pkg.sv
// Shared constants for the stepper current/status register link.
// Assumes one clock domain shared by the host end and the device end.
`default_nettype none
package scr_pkg;
   // Driver addressing
   localparam int          NUM_AXES_DFLT   = 4;
   localparam logic [3:0]  DRV_X           = 4'h0;
   localparam logic [3:0]  DRV_BROADCAST   = 4'h9;
   // Register addresses (7-bit register field)
   localparam logic [6:0]  REG_GLOBAL_STAT = 7'h01;
   localparam logic [6:0]  REG_HOLD_RUN    = 7'h10;
   // Field layout of hold_run_current_control
   localparam int          HOLD_LSB        = 0;
   localparam int          RUN_LSB         = 8;
   localparam int          DELAY_LSB       = 16;
   localparam int          CUR_W           = 5;
   localparam int          DELAY_W         = 4;
   // Values after reset, and the lowest run code the host sends
   localparam logic [4:0]  HOLD_RST        = 5'h08;
   localparam logic [4:0]  RUN_RST         = 5'h1F;
   localparam logic [3:0]  DELAY_RST       = 4'h1;
   localparam logic [4:0]  RUN_MIN         = 5'h08;
   // Bit positions of global_status_flags
   localparam int          STAT_RESET_BIT  = 0;
   localparam int          STAT_DRVERR_BIT = 1;
   localparam int          STAT_SUPPLY_BIT = 2;
   // Clocks per power-down step for delay code 1
   localparam int          STEP_CLOCKS_DFLT = 262144;
   // Synchroniser depth for the fault and supply pin inputs
   localparam int          SYNC_STAGES     = 2;
   // Host startup defaults for small motors
   localparam logic [4:0]  BOOT_HOLD_DFLT  = 5'h01;
   localparam logic [4:0]  BOOT_RUN_DFLT   = 5'h01;
   localparam logic [3:0]  BOOT_DELAY_DFLT = 4'h0;
endpackage
`default_nettype wire

// ===== core/scr_link_if.sv
// Register command link between the host end and the device end.
// Assumes both ends run on the same clock; no clocking block.
`default_nettype none
interface scr_link_if;
   logic        cmd_valid;   // One-cycle command strobe
   logic        cmd_write;   // 1 write, 0 read
   logic [3:0]  cmd_drv;     // Driver address
   logic [6:0]  cmd_reg;     // Register address
   logic [31:0] cmd_data;    // Data bytes 3..0
   logic        rsp_valid;   // One-cycle read reply strobe
   logic [31:0] rsp_data;    // Read reply data

   modport device (
      input  cmd_valid,
      input  cmd_write,
      input  cmd_drv,
      input  cmd_reg,
      input  cmd_data,
      output rsp_valid,
      output rsp_data
   );
   modport host (
      output cmd_valid,
      output cmd_write,
      output cmd_drv,
      output cmd_reg,
      output cmd_data,
      input  rsp_valid,
      input  rsp_data
   );
endinterface
`default_nettype wire

// ===== core/scr_device.sv
// Device end: per-axis current control registers, status flags and power-down ramp.
// Assumes the host end drives the link on the same clock; fault and supply pins are asynchronous, other pins are synchronous.
//
// Contract
// RULE1: Driver address picks axis; zero is X.
// RULE2: Host sends byte3 zero, delay, run bytes.
// RULE3: Host sends standstill current in byte 0.
// RULE4: Hold current resets 8, scales linearly.
// RULE5: Hold zero allows freewheel or brake selection.
// RULE6: Run current resets 31, scales linearly.
// RULE7: Host avoids run current below 8.
// RULE8: Ramp starts after standstill and timeout expire.
// RULE9: Delay resets 1; steps are code times 2^18.
// RULE10: Status flags clear by writing one.
// RULE11: Reset flag set; registers take reset values.
// RULE12: Error flag latches, holds while error active.
// RULE13: Supply low bit is live, not latched.
// RULE14: Status read has three meaningful bits.
// RULE15: Host lowers currents on every axis at startup.
// RULE16: Driver address 9 broadcasts to all axes.
`default_nettype none
module scr_device
   import scr_pkg::*;
#(
   parameter int NUM_AXES    = NUM_AXES_DFLT,
   parameter int STEP_CLOCKS = STEP_CLOCKS_DFLT
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   scr_link_if.device               link,
   input  wire logic [NUM_AXES-1:0] standstill_i,
   input  wire logic [NUM_AXES-1:0] pd_timeout_done_i,
   input  wire logic [NUM_AXES-1:0] brake_select_i,
   input  wire logic [NUM_AXES-1:0] fault_i,
   input  wire logic [NUM_AXES-1:0] supply_low_i,
   output logic [NUM_AXES-1:0][4:0] coil_current_o,
   output logic [NUM_AXES-1:0]      freewheel_o,
   output logic [NUM_AXES-1:0]      brake_o,
   output logic [NUM_AXES-1:0]      shutdown_o
);
   localparam int TMR_W = $clog2(15 * STEP_CLOCKS + 1);

   // Elaboration checks
   if (NUM_AXES < 1 || NUM_AXES > 9) begin : g_bad_axes
      $error("NUM_AXES must be 1 to 9");
   end
   if (STEP_CLOCKS < 1) begin : g_bad_step
      $error("STEP_CLOCKS must be at least 1");
   end
   // Longest step, code 15, must stay within a 31-bit count
   if (STEP_CLOCKS > 32'h0888_8888) begin : g_big_step
      $error("STEP_CLOCKS too large for the step timer");
   end

   // Two-flop synchronisers for fault and supply comparator pins
   // Only the second stage feeds logic; the first may be metastable
   logic [NUM_AXES-1:0] fault_s1_q;
   logic [NUM_AXES-1:0] fault_s2_q;
   logic [NUM_AXES-1:0] low_s1_q;
   logic [NUM_AXES-1:0] low_s2_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fault_s1_q <= '0;
         fault_s2_q <= '0;
         low_s1_q   <= '0;
         low_s2_q   <= '0;
      end else begin
         fault_s1_q <= fault_i;
         fault_s2_q <= fault_s1_q;
         low_s1_q   <= supply_low_i;
         low_s2_q   <= low_s1_q;
      end
   end

   // Per-axis register state, one slice per axis
   logic [NUM_AXES-1:0][4:0]         hold_q;
   logic [NUM_AXES-1:0][4:0]         run_q;
   logic [NUM_AXES-1:0][3:0]         delay_q;
   logic [NUM_AXES-1:0]              rst_flag_q;
   logic [NUM_AXES-1:0]              drv_err_q;

   // Per-axis register bank and ramp
   for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
      logic             sel;
      logic [4:0]       hold_d;
      logic [4:0]       run_d;
      logic [4:0]       cur_d;
      logic [3:0]       delay_d;
      logic             rst_flag_d;
      logic             drv_err_d;
      logic             fw_d;
      logic             br_d;
      logic             pd_active;
      logic [TMR_W-1:0] tmr_q;
      logic [TMR_W-1:0] tmr_d;
      logic [TMR_W-1:0] step_lim;

      // Command decode and next register values
      always_comb begin
         sel = link.cmd_valid && link.cmd_write &&
               (link.cmd_drv == 4'(a) || link.cmd_drv == DRV_BROADCAST); // RULE1 RULE16
         hold_d     = hold_q[a];
         run_d      = run_q[a];
         delay_d    = delay_q[a];
         rst_flag_d = rst_flag_q[a];
         drv_err_d  = drv_err_q[a];
         if (sel && link.cmd_reg == REG_HOLD_RUN) begin
            hold_d  = link.cmd_data[HOLD_LSB +: CUR_W];   // RULE4
            run_d   = link.cmd_data[RUN_LSB +: CUR_W];    // RULE6
            delay_d = link.cmd_data[DELAY_LSB +: DELAY_W]; // RULE9
         end
         if (sel && link.cmd_reg == REG_GLOBAL_STAT) begin
            if (link.cmd_data[STAT_RESET_BIT])
               rst_flag_d = 1'b0; // RULE10
            if (link.cmd_data[STAT_DRVERR_BIT] && !fault_s2_q[a])
               drv_err_d = 1'b0; // RULE10 RULE12
         end
         // Set wins: a live fault overrides a clearing write
         if (fault_s2_q[a])
            drv_err_d = 1'b1; // RULE12
      end

      // Power-down ramp from run current toward hold current
      always_comb begin
         pd_active = standstill_i[a] && pd_timeout_done_i[a]; // RULE8
         step_lim  = TMR_W'(delay_q[a]) * TMR_W'(STEP_CLOCKS); // RULE9
         cur_d     = coil_current_o[a];
         tmr_d     = '0;
         if (!pd_active) begin
            cur_d = run_q[a]; // RULE6
         end else if (coil_current_o[a] > hold_q[a]) begin
            if (delay_q[a] == 4'h0) begin
               cur_d = hold_q[a]; // RULE9
            end else if (tmr_q >= step_lim - TMR_W'(1)) begin
               cur_d = coil_current_o[a] - 5'h01; // RULE8
            end else begin
               tmr_d = tmr_q + TMR_W'(1);
            end
         end else begin
            cur_d = hold_q[a]; // RULE4
         end
         fw_d = pd_active && hold_q[a] == 5'h00 && cur_d == 5'h00 && !brake_select_i[a]; // RULE5
         br_d = pd_active && hold_q[a] == 5'h00 && cur_d == 5'h00 && brake_select_i[a];  // RULE5
      end

      // Register bank returns to reset values on reset
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            hold_q[a]     <= HOLD_RST;  // RULE11
            run_q[a]      <= RUN_RST;
            delay_q[a]    <= DELAY_RST;
            rst_flag_q[a] <= 1'b1;      // RULE11
            drv_err_q[a]  <= 1'b0;
         end else begin
            hold_q[a]     <= hold_d;
            run_q[a]      <= run_d;
            delay_q[a]    <= delay_d;
            rst_flag_q[a] <= rst_flag_d;
            drv_err_q[a]  <= drv_err_d;
         end
      end

      // Ramp state and pin outputs; coil starts at the run reset value
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            tmr_q             <= '0;
            coil_current_o[a] <= RUN_RST;
            freewheel_o[a]    <= 1'b0;
            brake_o[a]        <= 1'b0;
            shutdown_o[a]     <= 1'b0;
         end else begin
            tmr_q             <= tmr_d;
            coil_current_o[a] <= cur_d;
            freewheel_o[a]    <= fw_d;
            brake_o[a]        <= br_d;
            shutdown_o[a]     <= fault_s2_q[a]; // Bridge off on fault
         end
      end
   end

   // Read reply: status only, other registers read zero
   // Reply word moves only on a read, so live flags cannot disturb it
   logic        rsp_valid_d;
   logic [31:0] rsp_data_d;
   always_comb begin
      rsp_valid_d = link.cmd_valid && !link.cmd_write;
      rsp_data_d  = link.rsp_data;
      if (rsp_valid_d) begin
         rsp_data_d = 32'h0000_0000;
         for (int a = 0; a < NUM_AXES; a++) begin
            if (link.cmd_drv == 4'(a) && link.cmd_reg == REG_GLOBAL_STAT) begin
               rsp_data_d[STAT_RESET_BIT]  = rst_flag_q[a]; // RULE14
               rsp_data_d[STAT_DRVERR_BIT] = drv_err_q[a];
               rsp_data_d[STAT_SUPPLY_BIT] = low_s2_q[a];   // RULE13
            end
         end
      end
   end

   // Reply strobe and held reply word
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         link.rsp_valid <= 1'b0;
         link.rsp_data  <= 32'h0000_0000;
      end else begin
         link.rsp_valid <= rsp_valid_d;
         link.rsp_data  <= rsp_data_d;
      end
   end
endmodule
`default_nettype wire

// ===== core/scr_host.sv
// Host end: startup broadcast of low currents, then user register commands.
// Assumes the device end answers reads one cycle after the command.
`default_nettype none
module scr_host
   import scr_pkg::*;
#(
   parameter logic [4:0] BOOT_HOLD  = BOOT_HOLD_DFLT,
   parameter logic [4:0] BOOT_RUN   = BOOT_RUN_DFLT,
   parameter logic [3:0] BOOT_DELAY = BOOT_DELAY_DFLT
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   scr_link_if.host         link,
   input  wire logic        req_i,
   input  wire logic        req_write_i,
   input  wire logic [3:0]  req_drv_i,
   input  wire logic [6:0]  req_reg_i,
   input  wire logic [31:0] req_data_i,
   output logic             busy_o,
   output logic             rd_valid_o,
   output logic [31:0]      rd_data_o
);
   typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_WAIT} scr_host_state_t;

   // Startup run code is raised to the minimum so a low default cannot slip through
   localparam logic [4:0] BOOT_RUN_SAFE = (BOOT_RUN < RUN_MIN) ? RUN_MIN : BOOT_RUN; // RULE7

   scr_host_state_t state_q, state_d;
   logic        valid_d, write_d, busy_d, rdv_d;
   logic [3:0]  drv_d;
   logic [6:0]  reg_d;
   logic [31:0] data_d, rdd_d;
   logic [4:0]  run_clamp;

   // Command sequencing
   always_comb begin
      state_d   = state_q;
      valid_d   = 1'b0;
      write_d   = link.cmd_write;
      drv_d     = link.cmd_drv;
      reg_d     = link.cmd_reg;
      data_d    = link.cmd_data;
      busy_d    = busy_o;
      rdv_d     = 1'b0;
      rdd_d     = rd_data_o;
      run_clamp = (req_data_i[RUN_LSB +: CUR_W] < RUN_MIN) ? RUN_MIN : req_data_i[RUN_LSB +: CUR_W]; // RULE7
      case (state_q)
         ST_BOOT: begin
            valid_d = 1'b1;           // RULE15
            write_d = 1'b1;
            drv_d   = DRV_BROADCAST;  // RULE16
            reg_d   = REG_HOLD_RUN;
            data_d  = {8'h00, 4'h0, BOOT_DELAY, 3'h0, BOOT_RUN_SAFE, 3'h0, BOOT_HOLD}; // RULE2 RULE3
            busy_d  = 1'b0;
            state_d = ST_IDLE;
         end
         ST_IDLE: begin
            if (req_i) begin
               valid_d = 1'b1;
               write_d = req_write_i;
               drv_d   = req_drv_i; // RULE1
               reg_d   = req_reg_i;
               data_d  = req_data_i;
               if (req_write_i && req_reg_i == REG_HOLD_RUN)
                  data_d = {8'h00, 4'h0, req_data_i[DELAY_LSB +: DELAY_W], 3'h0, run_clamp,
                            3'h0, req_data_i[HOLD_LSB +: CUR_W]}; // RULE2 RULE3
               if (!req_write_i) begin
                  busy_d  = 1'b1;
                  state_d = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (link.rsp_valid) begin
               rdv_d   = 1'b1;
               rdd_d   = link.rsp_data;
               busy_d  = 1'b0;
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q        <= ST_BOOT;
         link.cmd_valid <= 1'b0;
         link.cmd_write <= 1'b0;
         link.cmd_drv   <= DRV_X;
         link.cmd_reg   <= 7'h00;
         link.cmd_data  <= 32'h0000_0000;
         busy_o         <= 1'b1;
         rd_valid_o     <= 1'b0;
         rd_data_o      <= 32'h0000_0000;
      end else begin
         state_q        <= state_d;
         link.cmd_valid <= valid_d;
         link.cmd_write <= write_d;
         link.cmd_drv   <= drv_d;
         link.cmd_reg   <= reg_d;
         link.cmd_data  <= data_d;
         busy_o         <= busy_d;
         rd_valid_o     <= rdv_d;
         rd_data_o      <= rdd_d;
      end
   end
endmodule
`default_nettype wire

// ===== bench/scr_link_checker.sv
// Checker for the register command link between host and device ends.
// Assumes tb instantiates it beside the link, on the shared clock.
`default_nettype none
module scr_link_checker
   import scr_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cmd_valid,
   input wire logic        cmd_write,
   input wire logic [3:0]  cmd_drv,
   input wire logic [6:0]  cmd_reg,
   input wire logic [31:0] cmd_data,
   input wire logic        rsp_valid,
   input wire logic [31:0] rsp_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // One clock domain for every property
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Command kinds
   logic rd;
   assign rd = cmd_valid && !cmd_write;
   sequence s_hr_wr;
      cmd_valid && cmd_write && cmd_reg == REG_HOLD_RUN;
   endsequence
   // Link properties
   property p_rd_answer; rd |=> rsp_valid; endproperty
   property p_rsp_cause; rsp_valid |-> $past(rd); endproperty
   property p_stat_bits; rsp_valid |-> rsp_data[31:3] == 29'h0; endproperty
   property p_other_zero; rd && (cmd_reg != REG_GLOBAL_STAT || cmd_drv == DRV_BROADCAST) |=> rsp_data == 32'h0;
   endproperty
   property p_rsp_hold; !rsp_valid |-> $stable(rsp_data); endproperty
   property p_boot;
      $fell(rst_i) |-> ##[0:3] (cmd_valid && cmd_write && cmd_reg == REG_HOLD_RUN && cmd_drv == DRV_BROADCAST);
   endproperty
   property p_hr_form; s_hr_wr |-> cmd_data[31:24] == 8'h0 && cmd_data[12:8] >= RUN_MIN; endproperty
   property p_hr_rsvd; s_hr_wr |-> {cmd_data[23:20], cmd_data[15:13], cmd_data[7:5]} == 10'h0; endproperty
   property p_rd_gap; rd |=> !cmd_valid [*2]; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read without reply");
   a_rsp_cause: assert property (p_rsp_cause) else $error("reply without read");
   a_stat_bits: assert property (p_stat_bits) else $error("upper reply bits set");
   a_other_zero: assert property (p_other_zero) else $error("nonzero reply");
   a_rsp_hold: assert property (p_rsp_hold) else $error("reply data moved");
   a_boot: assert property (p_boot) else $error("no startup broadcast");
   a_hr_form: assert property (p_hr_form) else $error("bad current word");
   a_hr_rsvd: assert property (p_hr_rsvd) else $error("reserved bits set");
   a_rd_gap: assert property (p_rd_gap) else $error("command during read");
   // Main scenarios
   c_boot: cover property (cmd_valid && cmd_drv == DRV_BROADCAST);
   c_stat: cover property (rd && cmd_reg == REG_GLOBAL_STAT ##1 rsp_data[0]);
   c_w1c: cover property (cmd_valid && cmd_write && cmd_reg == REG_GLOBAL_STAT);
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench joining host and device ends over the link.
// Assumes a 25 MHz clock and a short power-down step of 4 clocks.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import scr_pkg::*;
   localparam int SC = 4;
   logic              clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              req = 1'b0, rw = 1'b0;
   logic [3:0]        rdrv = 4'h0, stst = 4'h0, tmo = 4'h0, brk = 4'h0, flt = 4'h0, slo = 4'h0;
   logic [6:0]        rreg = 7'h00;
   logic [31:0]       rdat = 32'h0, rdd;
   logic              busy, rdv;
   logic [3:0][4:0]   coil;
   logic [3:0]        fw, bk, sd;
   int                n_errors = 0, compares = 0;
   scr_link_if link ();
   scr_host #(.BOOT_RUN(5'h08)) scr_host_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link), .req_i(req),
      .req_write_i(rw), .req_drv_i(rdrv), .req_reg_i(rreg), .req_data_i(rdat), .busy_o(busy),
      .rd_valid_o(rdv), .rd_data_o(rdd));
   scr_device #(.STEP_CLOCKS(SC)) scr_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link),
      .standstill_i(stst), .pd_timeout_done_i(tmo), .brake_select_i(brk), .fault_i(flt),
      .supply_low_i(slo), .coil_current_o(coil), .freewheel_o(fw), .brake_o(bk), .shutdown_o(sd));
   scr_link_checker scr_link_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid(link.cmd_valid),
      .cmd_write(link.cmd_write), .cmd_drv(link.cmd_drv), .cmd_reg(link.cmd_reg),
      .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));
   // Clock
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // Expected words
   function automatic logic [31:0] hr(input logic [4:0] h, input logic [4:0] r, input logic [3:0] d);
      return {12'h0, d, 3'h0, r, 3'h0, h};
   endfunction
   function automatic logic [31:0] stat(input logic r, input logic e, input logic s);
      return {29'h0, s, e, r};
   endfunction
   task automatic tally_and_finish();
      if (n_errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Compare tasks
   task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected reply at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task automatic cmp_pin(input logic [4:0] got, input logic [4:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected pin at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   // Bounded wait step
   task automatic tick(inout int i);
      @(negedge clk_i);
      i++;
      if (i > 400) begin
         n_errors++;
         tally_and_finish();
      end
   endtask
   task automatic send(input logic w, input logic [3:0] d, input logic [6:0] r, input logic [31:0] x);
      int i = 0;
      while (busy !== 1'b0) begin
         tick(i);
      end
      {req, rw, rdrv, rreg, rdat} = {1'b1, w, d, r, x};
      @(negedge clk_i);
      req = 1'b0;
      repeat (2) @(negedge clk_i);
   endtask
   task automatic rdc(input logic [3:0] d, input logic [6:0] r, input logic [31:0] e);
      int i = 0;
      send(1'b0, d, r, 32'h0);
      while (rdv !== 1'b1) begin
         tick(i);
      end
      cmp_data(rdd, e);
   endtask
   // Main sequence
   initial begin
      int i;
      int k;
      logic [4:0] r;
      void'($urandom(13));
      repeat (6) @(negedge clk_i);
      cmp_pin(coil[0], RUN_RST);
      cmp_pin({4'h0, busy}, 5'h01);
      rst_i = 1'b0;
      send(1'b0, DRV_X, 7'h7F, 32'h0);
      for (k = 0; k < 4; k++) begin
         cmp_pin(coil[k], 5'h08);
      end
      rdc(DRV_X, REG_GLOBAL_STAT, stat(1'b1, 1'b0, 1'b0));
      send(1'b1, DRV_X, REG_GLOBAL_STAT, 32'h1);
      rdc(DRV_X, REG_GLOBAL_STAT, stat(1'b0, 1'b0, 1'b0));
      {flt, slo} = {4'h2, 4'h4};
      repeat (4) @(negedge clk_i);
      cmp_pin({4'h0, sd[1]}, 5'h01);
      send(1'b1, 4'h1, REG_GLOBAL_STAT, 32'h2);
      rdc(4'h1, REG_GLOBAL_STAT, stat(1'b1, 1'b1, 1'b0));
      rdc(4'h2, REG_GLOBAL_STAT, stat(1'b1, 1'b0, 1'b1));
      {flt, slo} = {4'h0, 4'h0};
      repeat (4) @(negedge clk_i);
      rdc(4'h1, REG_GLOBAL_STAT, stat(1'b1, 1'b1, 1'b0));
      rdc(4'h2, REG_GLOBAL_STAT, stat(1'b1, 1'b0, 1'b0));
      send(1'b1, 4'h1, REG_GLOBAL_STAT, 32'h3);
      rdc(4'h1, REG_GLOBAL_STAT, stat(1'b0, 1'b0, 1'b0));
      rdc(DRV_X, REG_HOLD_RUN, 32'h0);
      rdc(DRV_BROADCAST, REG_GLOBAL_STAT, 32'h0);
      send(1'b1, 4'h5, REG_HOLD_RUN, hr(5'h01, 5'h14, 4'h0));
      cmp_pin(coil[0], 5'h08);
      // Random run codes on axis X, edges first
      for (k = 0; k < 6; k++) begin
         r = (k == 0) ? 5'h08 : (k == 1) ? 5'h1F : 5'(8 + $urandom_range(23));
         send(1'b1, DRV_X, REG_HOLD_RUN, hr(5'($urandom), r, 4'($urandom)));
         cmp_pin(coil[0], r);
         cmp_pin(coil[1], 5'h08);
      end
      // Power-down ramp on axis X
      send(1'b1, DRV_X, REG_HOLD_RUN, hr(5'h05, 5'h14, 4'h2));
      stst = 4'h1;
      repeat (20) @(negedge clk_i);
      cmp_pin(coil[0], 5'h14);
      tmo = 4'h1;
      i = 0;
      while (coil[0] === 5'h14) begin
         tick(i);
      end
      i = 0;
      while (coil[0] === 5'h13) begin
         tick(i);
      end
      cmp_pin(5'(i), 5'(2 * SC));
      while (coil[0] !== 5'h05) begin
         tick(i);
      end
      send(1'b1, DRV_X, REG_HOLD_RUN, hr(5'h00, 5'h14, 4'h0));
      brk = 4'h1;
      repeat (3) @(negedge clk_i);
      cmp_pin(coil[0], 5'h00);
      cmp_pin({3'h0, fw[0], bk[0]}, 5'h01);
      brk = 4'h0;
      repeat (3) @(negedge clk_i);
      cmp_pin({3'h0, fw[0], bk[0]}, 5'h02);
      {stst, tmo} = {4'h0, 4'h0};
      send(1'b1, DRV_BROADCAST, REG_HOLD_RUN, hr(5'h03, 5'h10, 4'h1));
      for (k = 0; k < 4; k++) begin
         cmp_pin(coil[k], 5'h10);
      end
      // Second reset in mid-run
      rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      for (k = 0; k < 4; k++) begin
         cmp_pin(coil[k], RUN_RST);
      end
      rst_i = 1'b0;
      rdc(DRV_X, REG_GLOBAL_STAT, stat(1'b1, 1'b0, 1'b0));
      tally_and_finish();
   end
endmodule
`default_nettype wire
